// ===== design/asq_conv_timer.sv
/*
 * Internal oscillator divider and conversion timer.
 * Assumes start is a one-cycle pulse from the sequencer; a start while
 * busy is ignored. Length varies with oscillator phase at start.
 */
`timescale 1ns/1ps
module asq_conv_timer
    import asq_pkg::*;
#(
    parameter int DIV   = OSC_DIV,            // System cycles per tick
    parameter int TICKS = CONV_OSC_TICKS      // Ticks per conversion
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      osc_tick,
    output logic      busy,
    output logic      done
);

    logic [7:0] div_r;                        // Oscillator phase
    logic [7:0] tick_cnt_r;                   // Ticks spent in conversion
    logic [9:0] len_r;                        // Helper: cycles since start

    // ------------------------------------------------------------
    // Free-running oscillator enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || div_r == 8'(DIV - 1)) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    assign osc_tick = (div_r == 8'(DIV - 1));

    // ------------------------------------------------------------
    // Conversion clocked only by oscillator ticks
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy       <= 1'b0;
            done       <= 1'b0;
            tick_cnt_r <= 8'h00;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin             // [R9]
                busy       <= 1'b1;
                tick_cnt_r <= 8'h00;
            end else if (busy && osc_tick) begin
                if (tick_cnt_r == 8'(TICKS - 1)) begin
                    busy <= 1'b0;                 // Ends on a tick edge
                    done <= 1'b1;
                end else begin
                    tick_cnt_r <= tick_cnt_r + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst || (!busy && start)) begin
            len_r <= 10'h000;
        end else if (busy) begin
            len_r <= len_r + 10'h001;
        end
    end

    property p_conv_len;
        @(posedge sys_clk) disable iff (rst)
        done |-> (len_r >= 10'(CONV_MIN_CYC - 1)) && (len_r <= 10'(CONV_MAX_CYC - 1));
    endproperty
    a_conv_len: assert property (p_conv_len) // [R9]
        else $error("conversion length outside limits");

endmodule // asq_conv_timer

// ===== design/asq_pkg.sv
/*
 * Shared constants and carrier types of the converter state sequencer.
 * Assumes a single 100 MHz system clock; every time is given in ns and
 * turned into whole clock cycles here.
 */
package asq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;     // 100 MHz system clock
    localparam int MIN_CLEAR_LOW_NS = 100;    // Least low time of the clear pin
    localparam int RST_EXIT_NS      = 1000;   // Delay from clear release to acquire
    localparam int CONV_MIN_NS      = 300;    // Shortest conversion
    localparam int CONV_MAX_NS      = 500;    // Longest conversion
    // Least times round up, longest times round down
    localparam int MIN_CLEAR_LOW_CYC = (MIN_CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_EXIT_CYC      = (RST_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MIN_CYC      = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC      = CONV_MAX_NS / CLK_PERIOD_NS;
    // Internal oscillator as an enable from a divider
    localparam int OSC_DIV           = 4;     // System cycles per oscillator tick
    localparam int CONV_OSC_TICKS    = 9;     // Oscillator ticks per conversion

    // ------------------------------------------------------------
    // Result coding
    // ------------------------------------------------------------
    localparam int RES_W   = 20;              // Result width
    localparam int ANA_W   = 24;              // Width of the quantiser input
    localparam logic [19:0] CODE_NEG_FS = 20'h80000;  // Most negative code
    localparam logic [19:0] CODE_POS_FS = 20'h7FFFF;  // Most positive code
    localparam logic [19:0] CODE_RESET  = 20'h00000;  // Result after reset

    // ------------------------------------------------------------
    // Transfer clock selection
    // ------------------------------------------------------------
    localparam logic [1:0] XCLK_OSC  = 2'h0;  // Internal oscillator only
    localparam logic [1:0] XCLK_SCLK = 2'h1;  // Host serial clock only
    localparam logic [1:0] XCLK_BOTH = 2'h2;  // Either source

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_ACQ  = 4'h1,                       // Acquire
        ST_CNV  = 4'h2,                       // Convert
        ST_RST  = 4'h4,                       // Held in clear
        ST_EXIT = 4'h8                        // Waiting out the exit delay
    } asq_state_e;

    typedef struct packed {
        logic [19:0] data;                    // Upper twenty bits of the word
        logic [1:0]  tail;                    // Lower two bits, zero here
    } asq_word_s;

    typedef struct packed {
        logic clear_n;                        // Active-low clear pin
        logic trigger;                        // Conversion start pin
        logic cs_n;                           // Active-low chip select
        logic sclk;                           // Host serial clock
    } asq_pins_s;

endpackage

// ===== design/asq_sequencer.sv
/*
 * Functional-state sequencer of a 20-bit sampling converter core.
 * Assumes pins from the host arrive asynchronously and are synchronised
 * here; the quantiser code and the serial-side selects come from logic
 * on sys_clk.
 */
// Behaviour
// R1: Clear pin async; qualify low by minimum time.
// R2: Clear state: defaults, ready low, outputs undriven.
// R3: Host releases clear with trigger, clock low.
// R4: After exit delay, acquire and raise ready.
// R5: Acquire after power-up, reset, conversion end.
// R6: Clear falling while acquiring enters clear state.
// R7: Trigger rising in acquire starts a conversion.
// R8: Trigger edges ignored during a conversion.
// R9: Conversion timed by oscillator within limits.
// R10: Status flag low while converting.
// R11: Chip select high: ready mirrors status.
// R12: Result in saturating 20-bit two's complement.
// R13: Host waits ready rise or maximum time.
// R14: Host spaces conversions by conversion plus acquisition.
// R15: Host keeps clear high while operating.
// R16: Transfers clocked by oscillator, serial clock, both.
// R17: Core takes start, returns status and result.
// R18: Word upper bits carry latest result normally.
// R19: Result latched at end of conversion.
`timescale 1ns/1ps
module asq_sequencer
    import asq_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire asq_pkg::asq_pins_s        host_pins,
    input  wire logic signed [asq_pkg::ANA_W-1:0] analog_code,
    input  wire logic [1:0]                xfer_clk_sel,
    input  wire logic                      reg_read_sel,
    input  wire logic [7:0]                reg_read_byte,
    input  wire logic                      patn_sel,
    input  wire logic [19:0]               patn_word,
    output logic                           host_ready_indicator,
    output logic                           sdo_oe,
    output logic                           cfg_defaults,
    output logic                           conversion_status_flag,
    output asq_pkg::asq_word_s             out_word,
    output logic                           xfer_tick
);

    import asq_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    asq_pins_s   pins_s;                      // Synchronised pin levels
    asq_state_e  state_r;                     // Functional state
    asq_state_e  state_nxt;                   // Next functional state
    logic        trig_d_r;                    // Trigger, one cycle later
    logic        sclk_d_r;                    // Serial clock, one cycle later
    logic        trig_rise;                   // Rising trigger edge
    logic        sclk_rise;                   // Rising serial clock edge
    logic [7:0]  low_cnt_r;                   // Cycles the clear pin is low
    logic        clr_hit;                     // Clear held long enough
    logic [11:0] exit_cnt_r;                  // Cycles since clear release
    logic        conv_start;                  // One-cycle start to the core
    logic        conv_busy;                   // Core is converting
    logic        conv_done;                   // Core finished, one cycle
    logic        osc_tick;                    // Internal oscillator enable
    logic [19:0] sample_r;                    // Code captured at start
    logic [19:0] result_r;                    // Latest finished result
    logic        status_r;                    // Conversion status flag
    asq_word_s   word_nxt;                    // Next output word

    // Saturate the quantiser input to the 20-bit code range
    function automatic logic [19:0] sat_code(input logic signed [ANA_W-1:0] v);
        logic signed [ANA_W-1:0] lo;
        logic signed [ANA_W-1:0] hi;
        lo = -(ANA_W'(1) <<< (RES_W - 1));
        hi = (ANA_W'(1) <<< (RES_W - 1)) - ANA_W'(1);
        if (v < lo) begin
            sat_code = CODE_NEG_FS;
        end else if (v > hi) begin
            sat_code = CODE_POS_FS;
        end else begin
            sat_code = v[19:0];                // Zero stays zero, -1 all ones
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Idle levels: clear high, chip select high, others low
    asq_sync #(
        .W       (4),
        .RST_VAL (4'hA)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (host_pins),
        .pin_sync (pins_s)
    );

    // Edge detectors look only at the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trig_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
        end else begin
            trig_d_r <= pins_s.trigger;
            sclk_d_r <= pins_s.sclk;
        end
    end
    assign trig_rise = pins_s.trigger & ~trig_d_r;
    assign sclk_rise = pins_s.sclk & ~sclk_d_r;

    // ------------------------------------------------------------
    // Clear pin qualification
    // ------------------------------------------------------------
    // Glitches shorter than the minimum low time are rejected
    always_ff @(posedge sys_clk) begin
        if (rst || pins_s.clear_n) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'(MIN_CLEAR_LOW_CYC)) begin
            low_cnt_r <= low_cnt_r + 8'h01;    // [R1]
        end
    end
    assign clr_hit = (low_cnt_r == 8'(MIN_CLEAR_LOW_CYC - 1)) && !pins_s.clear_n;

    // Exit delay counter, runs only after the release
    always_ff @(posedge sys_clk) begin
        if (rst || state_r != ST_EXIT) begin
            exit_cnt_r <= 12'h000;
        end else begin
            exit_cnt_r <= exit_cnt_r + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // Functional state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        conv_start = 1'b0;
        case (state_r)
            ST_ACQ: begin
                if (clr_hit) begin
                    state_nxt = ST_RST;            // [R6]
                end else if (trig_rise) begin
                    state_nxt  = ST_CNV;           // [R7]
                    conv_start = 1'b1;             // [R17]
                end
            end
            ST_CNV: begin
                // Trigger edges are not looked at here
                if (clr_hit) begin
                    state_nxt = ST_RST;            // [R1]
                end else if (conv_done) begin
                    state_nxt = ST_ACQ;            // [R5] [R8]
                end
            end
            ST_RST: begin
                if (pins_s.clear_n) begin
                    state_nxt = ST_EXIT;
                end
            end
            ST_EXIT: begin
                if (clr_hit) begin
                    state_nxt = ST_RST;
                end else if (exit_cnt_r == 12'(RST_EXIT_CYC - 1)) begin
                    state_nxt = ST_ACQ;            // [R4]
                end
            end
            default: begin
                state_nxt = ST_ACQ;
            end
        endcase
    end

    // Power-up lands in acquire
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_ACQ;                     // [R5]
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Converter core timing
    // ------------------------------------------------------------
    // A clear during a conversion leaves the timer to finish; its
    // done pulse is then ignored because the state is no longer convert
    asq_conv_timer #(
        .DIV   (OSC_DIV),
        .TICKS (CONV_OSC_TICKS)
    ) u_timer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (conv_start),
        .osc_tick (osc_tick),
        .busy     (conv_busy),
        .done     (conv_done)
    );

    // Status flag low for the whole conversion; it rises on the same edge
    // as the return to acquire, so ready never lags the state by a cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_r <= 1'b1;
        end else if (conv_start) begin
            status_r <= 1'b0;                      // [R10]
        end else if (state_nxt != ST_CNV) begin
            status_r <= 1'b1;                      // [R10]
        end
    end
    assign conversion_status_flag = status_r;

    // ------------------------------------------------------------
    // Sample and result
    // ------------------------------------------------------------
    // Sample taken at start, result held until the next end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sample_r <= CODE_RESET;
            result_r <= CODE_RESET;
        end else begin
            if (conv_start) begin
                sample_r <= sat_code(analog_code); // [R12]
            end
            if (conv_done && state_r == ST_CNV) begin
                result_r <= sample_r;              // [R19] [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // Output word, frozen while a frame is open
    // ------------------------------------------------------------
    always_comb begin
        word_nxt.tail = 2'h0;
        if (reg_read_sel) begin
            word_nxt.data = {reg_read_byte, 12'h000};
        end else if (patn_sel) begin
            word_nxt.data = patn_word;
        end else begin
            word_nxt.data = result_r;              // [R18]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_word <= '0;
        end else if (pins_s.cs_n) begin
            out_word <= word_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pins toward the host
    // ------------------------------------------------------------
    // Ready low in clear and exit, low during a frame
    assign host_ready_indicator = (state_r == ST_ACQ || state_r == ST_CNV) && pins_s.cs_n && status_r; // [R11]
    assign sdo_oe               = !pins_s.cs_n && (state_r == ST_ACQ || state_r == ST_CNV); // [R2]
    assign cfg_defaults         = (state_r == ST_RST);  // [R2]

    // Transfer clock enable from the selected source
    always_comb begin
        case (xfer_clk_sel)
            XCLK_OSC:  xfer_tick = osc_tick;       // [R16]
            XCLK_SCLK: xfer_tick = sclk_rise;      // [R16]
            XCLK_BOTH: xfer_tick = osc_tick | sclk_rise;
            default:   xfer_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int EXIT_LAST = RST_EXIT_CYC - 1;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_clear_enter;
        clr_hit |=> state_r == ST_RST;
    endproperty
    a_clear_enter: assert property (p_clear_enter) // [R1] [R6]
        else $error("qualified clear did not enter clear state");

    property p_clear_pins;
        state_r == ST_RST |-> !host_ready_indicator && !sdo_oe && cfg_defaults;
    endproperty
    a_clear_pins: assert property (p_clear_pins) // [R2]
        else $error("pins wrong while in clear state");

    property p_exit_delay;
        (state_r == ST_ACQ) && $past(state_r == ST_EXIT) |-> $past(exit_cnt_r) == 12'(EXIT_LAST);
    endproperty
    a_exit_delay: assert property (p_exit_delay) // [R4]
        else $error("exit delay length wrong");

    property p_end_acq;
        conv_done && state_r == ST_CNV && !clr_hit |=> state_r == ST_ACQ && status_r;
    endproperty
    a_end_acq: assert property (p_end_acq) // [R5]
        else $error("conversion end did not return to acquire");

    property p_start;
        state_r == ST_ACQ && trig_rise && !clr_hit |=> state_r == ST_CNV && !status_r && conv_busy;
    endproperty
    a_start: assert property (p_start) // [R7] [R10]
        else $error("trigger edge did not start conversion");

    property p_ignore;
        state_r == ST_CNV |-> !conv_start;
    endproperty
    a_ignore: assert property (p_ignore) // [R8]
        else $error("restart during conversion");

    property p_mirror;
        pins_s.cs_n && state_r inside {ST_ACQ, ST_CNV} |-> host_ready_indicator == status_r;
    endproperty
    a_mirror: assert property (p_mirror) // [R11]
        else $error("ready does not follow status");

    property p_code;
        conv_start |=> sample_r == sat_code($past(analog_code));
    endproperty
    a_code: assert property (p_code) // [R12]
        else $error("result coding wrong");

    property p_hold;
        !(conv_done && state_r == ST_CNV) |=> $stable(result_r);
    endproperty
    a_hold: assert property (p_hold) // [R19]
        else $error("result changed outside conversion end");

    property p_word;
        pins_s.cs_n && !reg_read_sel && !patn_sel |=> out_word.data == $past(result_r) && out_word.tail == 2'h0;
    endproperty
    a_word: assert property (p_word) // [R18]
        else $error("output word not latest result");

    c_conv:  cover property (state_r == ST_CNV ##[1:100] state_r == ST_ACQ);
    c_clear: cover property (state_r == ST_RST ##[1:200] state_r == ST_ACQ);
    c_frame: cover property (sdo_oe && state_r == ST_CNV);

endmodule // asq_sequencer

// ===== design/asq_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the pins are asynchronous to sys_clk; only the second stage
 * may be read by other logic.
 */
`timescale 1ns/1ps
module asq_sync #(
    parameter int         W       = 4,        // Number of pins
    parameter logic [3:0] RST_VAL = 4'h0      // Level held during reset
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] meta_r;                     // First stage, read only below

    // ------------------------------------------------------------
    // Two stages, reset to the idle level of each pin
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_r   <= RST_VAL[W-1:0];
            pin_sync <= RST_VAL[W-1:0];
        end else begin
            meta_r   <= pin_in;
            pin_sync <= meta_r;
        end
    end

endmodule // asq_sync

// ===== verification/asq_host_model.sv
/*
 * Host controller model: drives clear, trigger, chip select and serial clock.
 * Assumes sys_clk at 100 MHz; every pin changes 1 ns after a rising edge.
 */
`timescale 1ns/1ps
module asq_host_model (
    input  wire logic          sys_clk,
    input  wire logic          ready,
    output asq_pkg::asq_pins_s pins
);
    import asq_pkg::*;
    // ----------------------------------------
    // Idle levels: clear high, serial clock still
    // ----------------------------------------
    initial pins = '{clear_n: 1'b1, trigger: 1'b0, cs_n: 1'b1, sclk: 1'b0};
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Clear pin; others parked so release is clean
    task automatic set_clear(logic v);
        step(1);
        pins = '{clear_n: v, trigger: 1'b0, cs_n: 1'b1, sclk: 1'b0};
    endtask
    task automatic set_cs(logic v);
        step(1);
        pins.cs_n = v;
    endtask
    // Serial clock only inside a frame, still otherwise
    task automatic burst(int rises);
        repeat (rises) begin
            step(2);
            pins.sclk = 1'b1;
            step(2);
            pins.sclk = 1'b0;
        end
    endtask
    // One conversion; optional stray edge while busy
    task automatic convert(int acq, logic bounce, output int waited);
        step(1);
        pins.trigger = 1'b1;
        step(4);
        pins.trigger = 1'b0;
        if (bounce) begin
            step(8);
            pins.trigger = 1'b1;
            step(3);
            pins.trigger = 1'b0;
        end
        waited = 0;
        // Ready rise awaited, bounded
        while (ready !== 1'b1 && waited < 100) begin
            step(1);
            waited++;
        end
        step(acq);                                 // Acquisition gap
    endtask
endmodule // asq_host_model

// ===== verification/tb.sv
/*
 * Self-checking bench of the converter state sequencer.
 * Assumes the host model drives the pins; results come from a queue model.
 */
`timescale 1ns/1ps
module tb;
    import asq_pkg::*;
    // ----------------------------------------
    // Signals and bench state
    // ----------------------------------------
    logic               sys_clk = 1'b0;
    logic               rst;
    asq_pins_s          pins;
    logic signed [23:0] analog_code;
    logic [1:0]         xfer_clk_sel;
    logic               reg_read_sel, patn_sel, follow, prev_st;
    logic [7:0]         reg_read_byte;
    logic [19:0]        patn_word, last_exp;
    logic               ready, sdo_oe, cfg_defaults, status, xfer_tick;
    asq_word_s          out_word, hold;
    logic [19:0]        exp_q[$];
    logic [23:0]        bnd[7] = '{24'h800000, 24'hF80000, 24'hF80001, 24'hFFFFFF, 24'h000000, 24'h07FFFF, 24'h7FFFFF};
    int                 n_fail, comparisons, seed, n_conv, n_done, low_cnt, pend, ticks, w, k;
    always #5 sys_clk = ~sys_clk;
    asq_host_model u_host (.sys_clk(sys_clk), .ready(ready), .pins(pins));
    asq_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .host_pins(pins), .analog_code(analog_code),
        .xfer_clk_sel(xfer_clk_sel), .reg_read_sel(reg_read_sel), .reg_read_byte(reg_read_byte),
        .patn_sel(patn_sel), .patn_word(patn_word), .host_ready_indicator(ready), .sdo_oe(sdo_oe),
        .cfg_defaults(cfg_defaults), .conversion_status_flag(status), .out_word(out_word),
        .xfer_tick(xfer_tick));
    // ----------------------------------------
    // Compare, saturate, close
    // ----------------------------------------
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic [19:0] sat(logic signed [23:0] v);
        if (v < 24'shF80000) return 20'h80000;
        if (v > 24'sh07FFFF) return 20'h7FFFF;
        return v[19:0];
    endfunction
    task automatic end_sim;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog: a hang counts as a failure
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_sim;
    end
    // Monitor: conversion length, result, ready mirror
    always @(negedge sys_clk) if (!rst) begin
        if (status === 1'b0) low_cnt++;
        if (prev_st === 1'b0 && status === 1'b1) begin
            chk(low_cnt >= CONV_MIN_CYC && low_cnt <= CONV_MAX_CYC, 1);
            low_cnt = 0;
            pend = 2;
            n_done++;
        end
        if (pend == 1) chk(out_word.data, exp_q.pop_front());
        if (pend > 0) pend--;
        if (follow) chk(ready, status);
        prev_st = status;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, analog_code, xfer_clk_sel, reg_read_byte, patn_word} = {1'b1, 54'h0};
        {reg_read_sel, patn_sel, follow, prev_st} = 4'h1;
        seed = 32'h1421;
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        u_host.step(5);
        chk(status, 1);
        chk(ready, 1);
        follow = 1'b1;
        // Boundary codes, then random; mixed gaps, one stray edge
        for (int i = 0; i < 14; i++) begin
            analog_code = (i < 7) ? bnd[i] : 24'($random(seed));
            last_exp = sat(analog_code);
            exp_q.push_back(last_exp);
            n_conv++;
            u_host.convert(i % 3, i == 2, w);
            chk(w < 100, 1);
        end
        u_host.step(60);
        chk(n_done, n_conv);
        // Frame: ready low, word frozen, tick sources
        follow = 1'b0;
        u_host.set_cs(1'b0);
        u_host.step(4);
        chk(ready, 0);
        chk(sdo_oe, 1);
        hold = out_word;
        patn_sel = 1'b1;
        patn_word = 20'($random(seed));
        for (int s = 0; s < 4; s++) begin
            u_host.step(1);
            xfer_clk_sel = 2'(s);
            ticks = 0;
            fork
                u_host.burst(5);
                repeat (40) @(negedge sys_clk) ticks += int'(xfer_tick);
            join
            chk(s == 2 ? ticks >= 10 : ticks == (s == 0 ? 10 : s == 1 ? 5 : 0), 1);
        end
        chk(out_word, hold);
        u_host.set_cs(1'b1);
        u_host.step(4);
        chk(out_word, {patn_word, 2'h0});
        reg_read_sel = 1'b1;
        reg_read_byte = 8'($random(seed));
        u_host.step(4);
        chk(out_word.data, {reg_read_byte, 12'h000});
        {reg_read_sel, patn_sel} = 2'h0;
        u_host.step(4);
        chk(out_word.data, last_exp);
        // Short clear glitch ignored, long one taken
        u_host.set_clear(1'b0);
        u_host.step(5);
        u_host.set_clear(1'b1);
        u_host.step(15);
        chk({cfg_defaults, ready}, 2'h1);
        u_host.set_clear(1'b0);
        u_host.step(15);
        chk({cfg_defaults, ready, sdo_oe}, 3'h4);
        u_host.set_clear(1'b1);
        k = 0;
        while (ready !== 1'b1 && k < 300) begin
            u_host.step(1);
            k++;
        end
        chk(k >= RST_EXIT_CYC && k <= RST_EXIT_CYC + 6, 1);
        chk(cfg_defaults, 0);
        follow = 1'b1;
        analog_code = 24'($random(seed));
        exp_q.push_back(sat(analog_code));
        n_conv++;
        u_host.convert(2, 1'b0, w);
        u_host.step(5);
        chk(n_done, n_conv);
        end_sim;
    end
endmodule // tb
